// File: bench/ccr_far_model.sv
// Purpose: far end agent (hub link, graphics bus or internal device)
// Assumes: one cycle open at a time, req held until done is seen
// Notes:   lat sets how many cycles after req the answer comes
module ccr_far_model
#(
    parameter logic [31:0] rval = 32'h0000_0000
)
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        req,
    input  wire logic [31:0] addr,
    input  wire logic [1:0]  lat,
    output logic             done,
    output logic [31:0]      rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_reg;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            wait_reg <= 2'h0;
        else if (!req || done)
            wait_reg <= 2'h0;
        else
            wait_reg <= wait_reg + 2'h1;
    end

    assign done = req && (wait_reg == lat);
    // outside the answer cycle the data is inverted, never left stale
    assign rdata = done ? (rval ^ addr) : ~(rval ^ addr);
endmodule // ccr_far_model

// File: bench/config_cycle_router_test.sv
// Purpose: self-checking bench of the configuration cycle router
// Assumes: far ends answer after 0 to 3 cycles
// Notes:   read data of forwarded cycles is the far end value xor address
module config_cycle_router_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 0, rstn = 0, io_req = 0, io_we = 0, io_ack;
    logic [15:0] io_addr = 16'h0000;
    logic [3:0] io_be = 4'h0, cyc_be;
    logic [3:0] m_be;
    logic [31:0] io_wdata = 32'h0000_0000, io_rdata, cyc_addr, cyc_wdata;
    logic cyc_we, hub_req, hub_done, gfx_req, gfx_type1, gfx_done;
    logic int_req, int_done, enable_bit;
    logic [31:0] hub_rd, gfx_rd, int_rd, rd, m_addr, m_wd;
    logic [1:0] lat = 2'h0, m_dest, m_aux;
    logic m_we;
    ccr_pkg::ccr_hub_e hub_cmd;
    int miscompares = 0, tests_run = 0;
    logic [31:0] far_val [4] = '{32'h0, 32'h0F0F_0000, 32'hA5A5_0000,
                                 32'h5A5A_0000};

    always #5 clock = ~clock;

    ccr_router dut (.clock(clock), .rstn(rstn), .io_req(io_req),
        .io_we(io_we), .io_addr(io_addr), .io_be(io_be),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
        .cyc_addr(cyc_addr), .cyc_be(cyc_be), .cyc_we(cyc_we),
        .cyc_wdata(cyc_wdata), .hub_link_req(hub_req),
        .hub_link_cmd(hub_cmd), .hub_link_done(hub_done),
        .hub_link_rdata(hub_rd), .gfx_req(gfx_req), .gfx_type1(gfx_type1),
        .gfx_done(gfx_done), .gfx_rdata(gfx_rd), .int_req(int_req),
        .int_done(int_done), .int_rdata(int_rd),
        .config_cycle_enable_bit(enable_bit));
    ccr_far_model #(.rval(32'h0F0F_0000)) int_m (.clock(clock),
        .rstn(rstn), .req(int_req), .addr(cyc_addr), .lat(lat),
        .done(int_done), .rdata(int_rd));
    ccr_far_model #(.rval(32'hA5A5_0000)) hub_m (.clock(clock),
        .rstn(rstn), .req(hub_req), .addr(cyc_addr), .lat(lat),
        .done(hub_done), .rdata(hub_rd));
    ccr_far_model #(.rval(32'h5A5A_0000)) gfx_m (.clock(clock),
        .rstn(rstn), .req(gfx_req), .addr(cyc_addr), .lat(lat),
        .done(gfx_done), .rdata(gfx_rd));

    // ****************************************
    // monitor: which far end saw the last cycle
    // ****************************************
    always @(posedge clock)
    begin
        if (int_req || hub_req || gfx_req)
        begin
            m_dest = int_req ? 2'd1 : (hub_req ? 2'd2 : 2'd3);
            m_aux = hub_req ? hub_cmd : (gfx_req ? {1'b0, gfx_type1} : 2'd0);
            m_addr = cyc_addr;
            m_we = cyc_we;
            m_be = cyc_be;
            m_wd = cyc_wdata;
        end
    end

    // ****************************************
    // compare and access tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // dest: 0 local/none, 1 internal, 2 hub link, 3 graphics
    task automatic run(input logic we, input logic [15:0] a,
        input logic [3:0] be, input logic [31:0] wd, input logic [1:0] dest,
        input logic [31:0] ea, input logic [1:0] aux);
        int n;
        @(negedge clock);
        m_dest = 2'd0;
        io_req = 1'b1;
        io_we = we;
        io_addr = a;
        io_be = be;
        io_wdata = wd;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (io_ack !== 1'b1 && n < 40);
        rd = io_rdata;
        io_req = 1'b0;
        chk_bit(n < 40, 1'b1);
        chk({30'h0, m_dest}, {30'h0, dest});
        if (dest != 2'd0)
        begin
            chk(m_addr, ea);
            chk({30'h0, m_aux}, {30'h0, aux});
            chk_bit(m_we, we);
            chk({28'h0, m_be}, {28'h0, be});
            if (we)
                chk(m_wd, wd);
            else
                chk(rd, far_val[dest] ^ ea);
        end
    endtask

    task automatic complete_run;
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        int devs [4] = '{0, 7, 15, 16};
        logic [31:0] idx;
        repeat (6) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        run(0, 16'h0CF8, 4'hF, 0, 0, 0, 0);
        chk(rd, 32'h0000_0000);
        run(1, 16'h0CF8, 4'hF, 32'hFFFF_FFFF, 0, 0, 0);
        run(0, 16'h0CF8, 4'hF, 0, 0, 0, 0);
        chk(rd, 32'h80FF_FFFC);
        chk_bit(enable_bit, 1'b1);
        run(1, 16'h0CF8, 4'h2, 32'h1234_5678, 2, 32'h0CF8, 0);
        run(0, 16'h0CF8, 4'h3, 0, 2, 32'h0CF8, 0);
        run(0, 16'h0CF8, 4'hF, 0, 0, 0, 0);
        chk(rd, 32'h80FF_FFFC);
        run(0, 16'h0080, 4'hF, 0, 2, 32'h0080, 0);
        run(1, 16'h0CF8, 4'hF, 32'h0000_0800, 0, 0, 0);
        chk_bit(enable_bit, 1'b0);
        run(0, 16'h0CFC, 4'hF, 0, 2, 32'h0CFC, 0);
        // bus zero is scanned before any bridge gets a number
        for (int d = 0; d < 4; d++)
        begin
            idx = 32'h8000_0004 | (d << 11);
            lat = d[1:0];
            run(1, 16'h0CF8, 4'hF, idx, 0, 0, 0);
            run(0, 16'h0CFC, 4'hF, 0, d < 3 ? 2'd1 : 2'd2, idx,
                d < 3 ? 2'd0 : 2'd1);
        end
        run(1, 16'h0CF8, 4'hF, 32'h8000_0818, 0, 0, 0);
        run(1, 16'h0CFC, 4'hF, 32'h0005_0307, 0, 0, 0);
        run(0, 16'h0CFF, 4'hF, 0, 0, 0, 0);
        chk(rd, 32'h0005_0300);
        foreach (devs[i])
        begin
            idx = 32'h8003_0210 | (devs[i] << 11);
            lat = 2'(3 - i);
            run(1, 16'h0CF8, 4'hF, idx, 0, 0, 0);
            run(1, 16'h0CFC, 4'h3, 32'hCAFE_0001, 3, (devs[i] < 16 ?
                32'h1 << (16 + devs[i]) : 32'h0) | 32'h0210, 0);
        end
        for (int b = 2; b < 7; b++)
        begin
            idx = 32'h8000_0A14 | (b << 16);
            lat = b[1:0];
            run(1, 16'h0CF8, 4'hF, idx, 0, 0, 0);
            if (b == 4 || b == 5)
                run(0, 16'h0CFC, 4'hF, 0, 3, {8'h00, idx[23:2], 2'b01}, 1);
            else if (b != 3)
                run(0, 16'h0CFC, 4'hF, 0, 2, {idx[31:2], 2'b01}, 2);
        end
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        complete_run();
    end
endmodule // config_cycle_router_test

// File: core/ccr_dec_if.sv
// Purpose: carries the index and bridge bus numbers to the route decoder
// Assumes: purely combinational path
// Notes:   router drives inputs, decoder drives results
interface ccr_dec_if;
    logic [31:0]         index;
    logic [7:0]          sec_bus;
    logic [7:0]          sub_bus;
    ccr_pkg::ccr_route_e route;
    logic [31:0]         gfx_addr;

    modport router (output index, sec_bus, sub_bus, input route, gfx_addr);
    modport decoder (input index, sec_bus, sub_bus, output route, gfx_addr);
endinterface : ccr_dec_if

// File: core/ccr_decode.sv
// Purpose: picks the destination of a configuration cycle and its address
// Assumes: index and bus numbers are stable while a cycle is open
// Notes:   combinational only
`include "ccr_params.svh"

module ccr_decode
(
    ccr_dec_if.decoder dec
);

    // one-hot select line for a device number, none for the upper half
    function automatic logic [15:0] ccr_idsel(input logic [4:0] dev);
        ccr_idsel = dev[4] ? 16'h0000 : (16'h0001 << dev[3:0]);
    endfunction

    wire [7:0] bus_num = dec.index[`CCR_BUS_MSB:`CCR_BUS_LSB];
    wire [4:0] dev_num = dec.index[`CCR_DEV_MSB:`CCR_DEV_LSB];
    wire       bus_zero = (bus_num == 8'h00);
    wire       is_int   = bus_zero && (dev_num <= `CCR_LAST_INT_DEV);
    wire       is_sec   = (bus_num == dec.sec_bus);
    wire       below    = (bus_num > dec.sec_bus) && (bus_num <= dec.sub_bus);

    // bus zero first, internal devices never leave
    // secondary match, subordinate window, else hub
    assign dec.route = is_int   ? ccr_pkg::CCR_ROUTE_INT :
                       bus_zero ? ccr_pkg::CCR_ROUTE_HUB_T0 :
                       is_sec   ? ccr_pkg::CCR_ROUTE_GFX_T0 :
                       below    ? ccr_pkg::CCR_ROUTE_GFX_T1 :
                                  ccr_pkg::CCR_ROUTE_HUB_T1;

    // idsel on the top lines, function and register below
    // fields carried as is, low bits mark type 1
    assign dec.gfx_addr = is_sec ?
        {ccr_idsel(dev_num), 5'h00,
         dec.index[`CCR_FUNC_MSB:`CCR_REG_LSB], `CCR_T0_LOW} :
        {8'h00, dec.index[`CCR_BUS_MSB:`CCR_REG_LSB], `CCR_T1_LOW};

endmodule // ccr_decode

// File: core/ccr_params.svh
// Purpose: constants of the configuration cycle router
// Assumes: processor I/O addresses are 16 bits, dword aligned with lanes
// Notes:   included by the router and the decoder
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

`define CCR_INDEX_ADDR    16'h0CF8
`define CCR_DATA_ADDR     16'h0CFC
`define CCR_INDEX_RESET   32'h0000_0000
`define CCR_INDEX_WMASK   32'h80FF_FFFC
`define CCR_ENABLE_BIT    31
`define CCR_BUS_MSB       23
`define CCR_BUS_LSB       16
`define CCR_DEV_MSB       15
`define CCR_DEV_LSB       11
`define CCR_FUNC_MSB      10
`define CCR_FUNC_LSB      8
`define CCR_REG_MSB       7
`define CCR_REG_LSB       2
`define CCR_LAST_INT_DEV  5'h02
`define CCR_BRIDGE_DEV    5'h01
`define CCR_BUSNUM_DW     6'h06
`define CCR_BUSNUM_RESET  8'h00
`define CCR_ALL_LANES     4'hF
`define CCR_T0_LOW        2'b00
`define CCR_T1_LOW        2'b01

`endif

// File: core/ccr_pkg.sv
// Purpose: types shared by the router and its decoder
// Assumes: nothing
// Notes:   route and state codes are internal only; hub codes go out on hub_link_cmd
package ccr_pkg;

    typedef enum logic [2:0]
    {
        CCR_ROUTE_INT    = 3'h0,
        CCR_ROUTE_HUB_T0 = 3'h1,
        CCR_ROUTE_HUB_T1 = 3'h2,
        CCR_ROUTE_GFX_T0 = 3'h3,
        CCR_ROUTE_GFX_T1 = 3'h4
    } ccr_route_e;

    typedef enum logic [1:0]
    {
        CCR_HUB_IO   = 2'h0,
        CCR_HUB_CFG0 = 2'h1,
        CCR_HUB_CFG1 = 2'h2
    } ccr_hub_e;

    typedef enum logic [2:0]
    {
        CCR_ST_IDLE = 3'b001,
        CCR_ST_WAIT = 3'b010,
        CCR_ST_DONE = 3'b100
    } ccr_state_e;

endpackage : ccr_pkg

// File: core/ccr_router.sv
// Purpose: turns processor I/O accesses at the index/data pair into
//          configuration cycles on internal, hub link or graphics bus
// Assumes: one processor access open at a time; far ends answer by done
// Notes:   bridge bus numbers live here, other internal registers outside
//
// Functional notes
// - decode index 0CF8h and data 0CFCh-0CFFh
// - configuration cycles generated only while enable bit set
// - each data access with enable set becomes a configuration cycle, except the bridge bus number dword, answered locally
// - bus field zero means logical bus zero
// - internal devices answer as numbers 0,1,2
// - internal cycles never go to hub link
// - other bus zero devices go to hub
// - out of bridge range gives hub type 1
// - bridge primary bus number reads zero always
// - secondary bus match gives graphics type 0
// - device numbers 0-15 drive one-hot idsel line, 16-31 none
// - within subordinate range gives graphics type 1
// - partial index access passes through as I/O
// - index bits 30 to 24 read zero
`include "ccr_params.svh"

module ccr_router
(
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic                io_req,
    input  wire logic                io_we,
    input  wire logic [15:0]         io_addr,
    input  wire logic [3:0]          io_be,
    input  wire logic [31:0]         io_wdata,
    output logic      [31:0]         io_rdata,
    output logic                     io_ack,
    output logic      [31:0]         cyc_addr,
    output logic      [3:0]          cyc_be,
    output logic                     cyc_we,
    output logic      [31:0]         cyc_wdata,
    output logic                     hub_link_req,
    output ccr_pkg::ccr_hub_e        hub_link_cmd,
    input  wire logic                hub_link_done,
    input  wire logic [31:0]         hub_link_rdata,
    output logic                     gfx_req,
    output logic                     gfx_type1,
    input  wire logic                gfx_done,
    input  wire logic [31:0]         gfx_rdata,
    output logic                     int_req,
    input  wire logic                int_done,
    input  wire logic [31:0]         int_rdata,
    output logic                     config_cycle_enable_bit
);

    ccr_dec_if dec_bus ();

    ccr_decode u_decode
    (
        .dec (dec_bus.decoder)
    );

    //************************************************************
    // state
    //************************************************************
    ccr_pkg::ccr_state_e state_reg, state_next;
    ccr_pkg::ccr_hub_e   cmd_reg, cmd_next;
    logic [31:0] index_reg;
    logic [7:0]  sec_reg;
    logic [7:0]  sub_reg;
    logic [2:0]  tgt_reg, tgt_next;
    logic        gtype_reg;

    //************************************************************
    // access decode
    //************************************************************
    wire idle      = (state_reg == ccr_pkg::CCR_ST_IDLE);
    wire start     = idle && io_req;
    wire [15:0] index_base = `CCR_INDEX_ADDR;
    wire [15:0] data_base  = `CCR_DATA_ADDR;
    wire hit_index = (io_addr[15:2] == index_base[15:2]);
    wire hit_data  = (io_addr[15:2] == data_base[15:2]);
    // only a full dword touches the index register
    wire index_dw  = hit_index && (io_be == `CCR_ALL_LANES);
    // data window works only with the enable bit set
    wire cfg_on    = index_reg[`CCR_ENABLE_BIT];
    wire cfg_cycle = hit_data && cfg_on;
    wire [4:0] dev_num = index_reg[`CCR_DEV_MSB:`CCR_DEV_LSB];
    wire [5:0] reg_dw  = index_reg[`CCR_REG_MSB:`CCR_REG_LSB];
    wire is_int    = (dec_bus.route == ccr_pkg::CCR_ROUTE_INT);
    wire busnum_dw = is_int && (dev_num == `CCR_BRIDGE_DEV)
                     && (index_reg[`CCR_FUNC_MSB:`CCR_FUNC_LSB] == 3'h0)
                     && (reg_dw == `CCR_BUSNUM_DW);
    wire local_hit = index_dw || (cfg_cycle && busnum_dw);
    wire is_gfx    = (dec_bus.route == ccr_pkg::CCR_ROUTE_GFX_T0)
                     || (dec_bus.route == ccr_pkg::CCR_ROUTE_GFX_T1);
    // only hub type 1 sets bit 0 of the index address; internal stays 00
    wire hub_t1    = (dec_bus.route == ccr_pkg::CCR_ROUTE_HUB_T1);
    wire [31:0] index_rd = index_reg & `CCR_INDEX_WMASK;
    // primary bus number byte is wired to zero
    wire [31:0] busnum_rd = {8'h00, sub_reg, sec_reg, 8'h00};

    assign dec_bus.index   = index_reg;
    assign dec_bus.sec_bus = sec_reg;
    assign dec_bus.sub_bus = sub_reg;

    // target one-hot: [0] hub link, [1] graphics bus, [2] internal
    // data accesses with enable set become configuration cycles, except the bus number dword answered locally
    // internal route never picks the hub link
    assign tgt_next = !cfg_cycle ? 3'b001 :
                      is_int     ? 3'b100 :
                      is_gfx     ? 3'b010 : 3'b001;
    // hub gets bus zero outsiders, out of range buses, and I/O
    assign cmd_next =
        !cfg_cycle ? ccr_pkg::CCR_HUB_IO :
        (dec_bus.route == ccr_pkg::CCR_ROUTE_HUB_T0) ?
            ccr_pkg::CCR_HUB_CFG0 : ccr_pkg::CCR_HUB_CFG1;

    //************************************************************
    // sequencing
    //************************************************************
    wire tgt_done = (tgt_reg[0] && hub_link_done) || (tgt_reg[1] && gfx_done)
                    || (tgt_reg[2] && int_done);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ccr_pkg::CCR_ST_IDLE:
                if (io_req)
                    state_next = local_hit ? ccr_pkg::CCR_ST_DONE
                                           : ccr_pkg::CCR_ST_WAIT;
            ccr_pkg::CCR_ST_WAIT:
                if (tgt_done)
                    state_next = ccr_pkg::CCR_ST_DONE;
            ccr_pkg::CCR_ST_DONE:
                state_next = ccr_pkg::CCR_ST_IDLE;
            default:
                state_next = ccr_pkg::CCR_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state_reg <= ccr_pkg::CCR_ST_IDLE;
        else
            state_reg <= state_next;
    end

    //************************************************************
    // index and bridge bus number registers
    //************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            index_reg <= `CCR_INDEX_RESET;
        // full dword write, reserved bits never stored
        else if (start && index_dw && io_we)
            index_reg <= io_wdata & `CCR_INDEX_WMASK;
    end

    // bus numbers are per lane; lane 0 write is dropped on purpose
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sec_reg <= `CCR_BUSNUM_RESET;
            sub_reg <= `CCR_BUSNUM_RESET;
        end
        else if (start && cfg_cycle && busnum_dw && io_we)
        begin
            if (io_be[1])
                sec_reg <= io_wdata[15:8];
            if (io_be[2])
                sub_reg <= io_wdata[23:16];
        end
    end

    //************************************************************
    // outgoing cycle and read data
    //************************************************************
    // cycle fields are latched at start so they hold for the far end
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            tgt_reg   <= 3'b000;
            cmd_reg   <= ccr_pkg::CCR_HUB_IO;
            gtype_reg <= 1'b0;
            cyc_addr  <= 32'h0000_0000;
            cyc_be    <= 4'h0;
            cyc_we    <= 1'b0;
            cyc_wdata <= 32'h0000_0000;
        end
        else if (start && !local_hit)
        begin
            tgt_reg   <= tgt_next;
            cmd_reg   <= cmd_next;
            gtype_reg <= (dec_bus.route == ccr_pkg::CCR_ROUTE_GFX_T1);
            // I/O uses its own address; internal and hub config the index; graphics the mapped address
            // graphics address shaped by the decoder
            cyc_addr  <= !cfg_cycle ? {16'h0000, io_addr[15:2], 2'b00} :
                         is_gfx     ? dec_bus.gfx_addr :
                         index_rd | {31'h0000_0000, hub_t1};
            cyc_be    <= io_be;
            cyc_we    <= io_we;
            cyc_wdata <= io_wdata;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            io_rdata <= 32'h0000_0000;
        else if (start && index_dw)
            io_rdata <= index_rd;
        else if (start && local_hit)
            io_rdata <= busnum_rd;
        else if (state_reg == ccr_pkg::CCR_ST_WAIT && tgt_done)
            io_rdata <= tgt_reg[0] ? hub_link_rdata :
                        tgt_reg[1] ? gfx_rdata : int_rdata;
    end

    wire waiting = (state_reg == ccr_pkg::CCR_ST_WAIT);
    assign hub_link_req = waiting && tgt_reg[0];
    assign gfx_req      = waiting && tgt_reg[1];
    assign int_req      = waiting && tgt_reg[2];
    assign hub_link_cmd = cmd_reg;
    assign gfx_type1    = gtype_reg;
    assign io_ack       = (state_reg == ccr_pkg::CCR_ST_DONE);
    assign config_cycle_enable_bit = cfg_on;

    //************************************************************
    // checks
    //************************************************************
    default clocking ccr_cb @(posedge clock); endclocking
    default disable iff (!rstn);

    wire [7:0] cur_bus = index_reg[`CCR_BUS_MSB:`CCR_BUS_LSB];

    AST_PARTIAL_INDEX: assert property (
        start && hit_index && io_be != 4'hF |=> hub_link_req
        && hub_link_cmd == ccr_pkg::CCR_HUB_IO && $stable(index_reg))
        else $error("partial index access not passed through");
    AST_RESERVED_ZERO: assert property (
        index_reg[30:24] == 7'h00 && index_reg[1:0] == 2'b00)
        else $error("reserved index bits not zero");
    AST_DISABLED_NO_CFG: assert property (
        start && hit_data && !cfg_on |=> hub_link_req
        && hub_link_cmd == ccr_pkg::CCR_HUB_IO && !gfx_req && !int_req)
        else $error("configuration cycle while disabled");
    AST_INT_LOCAL: assert property (
        int_req |-> !hub_link_req && cur_bus == 8'h00
        && dev_num <= 5'h02)
        else $error("internal cycle misrouted");
    AST_HUB_T1_RANGE: assert property (
        hub_link_req && hub_link_cmd == ccr_pkg::CCR_HUB_CFG1 |->
        cur_bus != 8'h00 && (cur_bus < sec_reg || cur_bus > sub_reg)
        && cyc_addr[1:0] == 2'b01)
        else $error("hub type 1 out of place");
    AST_GFX_T0_ADDR: assert property (
        gfx_req && !gfx_type1 |-> cur_bus == sec_reg
        && $onehot0(cyc_addr[31:16]) && cyc_addr[1:0] == 2'b00
        && cyc_addr[31:16] == (dev_num[4] ? 16'h0 : 16'h1 << dev_num[3:0]))
        else $error("type 0 idsel wrong");
    AST_GFX_T1_ADDR: assert property (
        gfx_req && gfx_type1 |-> cur_bus > sec_reg && cur_bus <= sub_reg
        && cyc_addr[23:2] == index_reg[23:2] && cyc_addr[1:0] == 2'b01)
        else $error("type 1 address wrong");
    AST_DONE_ACKS: assert property (
        waiting && tgt_done |=> io_ack ##1 !io_ack && idle)
        else $error("finished cycle not acknowledged");
    AST_PRIMARY_ZERO: assert property (
        start && cfg_cycle && busnum_dw && !io_we |=> io_ack
        && io_rdata[7:0] == 8'h00 && io_rdata[15:8] == sec_reg)
        else $error("primary bus number not zero");

    COV_GFX_T0: cover property (gfx_req && !gfx_type1 && gfx_done);
    COV_GFX_T1: cover property (gfx_req && gfx_type1 && gfx_done);
    COV_HUB_T1: cover property (
        hub_link_req && hub_link_cmd == ccr_pkg::CCR_HUB_CFG1);
    COV_INDEX_WR: cover property (start && index_dw && io_we);

endmodule // ccr_router
